// File: suc_counter.sv
`timescale 1ns/1ns

module suc_counter (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic preset_bit0,
  input wire logic preset_bit1,
  input wire logic preset_bit2,
  input wire logic preset_bit3,
  input wire logic load_n,
  input wire logic parallel_count_enable_n,
  input wire logic trickle_count_enable_n,
  input wire logic count_direction,
  output logic count_bit0,
  output logic count_bit1,
  output logic count_bit2,
  output logic count_bit3,
  output logic ripple_carry_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // one step of the count, wrapping at both ends
  function automatic logic [3:0] stepCount(input logic [3:0] cnt, input logic up);
    logic [3:0] res;
    res = up ? 4'(cnt + suc_pkg::CNT_ONE) : 4'(cnt - suc_pkg::CNT_ONE);
    return res;
  endfunction

  // terminal count for the given direction
  function automatic logic atTerminal(input logic [3:0] cnt, input logic up);
    logic hit;
    hit = up ? (cnt == suc_pkg::CNT_MAX) : (cnt == suc_pkg::CNT_MIN);
    return hit;
  endfunction

  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic [3:0] presetVec;
  logic countGo;
  logic inhibit_r;
  logic [15:0] wraps_r;
  logic [15:0] wraps_nxt;
  logic wrapEvent;
  logic ack_r;
  logic [31:0] prdata_r;
  logic [31:0] rdMux;
  logic accessPh;
  logic xferDone;
  logic wrEn;
  logic hitStatus;
  logic hitWraps;
  logic hitCtrl;
  logic hitAny;
  logic termHit;

  // preset pins gathered, each bit independent of the others
  assign presetVec = {preset_bit3, preset_bit2, preset_bit1, preset_bit0};

  // both enables low and load inactive; software inhibit sits on top
  assign countGo = load_n && !parallel_count_enable_n && !trickle_count_enable_n
                   && !inhibit_r;

  // load wins over counting; a cascaded carry can drive load_n directly
  assign count_nxt = !load_n ? presetVec :
                     countGo ? stepCount(count_r, count_direction) :
                     count_r;

  // the wrap of this stage, as seen by software
  assign wrapEvent = countGo && load_n && atTerminal(count_r, count_direction);

  // all four bits in one register, one edge, no ripple
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_r <= suc_pkg::CNT_RST;
    end else if (clkEn) begin
      count_r <= count_nxt;
    end
  end

  assign count_bit0 = count_r[0];
  assign count_bit1 = count_r[1];
  assign count_bit2 = count_r[2];
  assign count_bit3 = count_r[3];

  // carry is pure gating, so a direction change shows at once;
  // enp is left out so chained stages see carry with enp high
  assign termHit = atTerminal(count_r, count_direction);
  assign ripple_carry_n = !(termHit && !trickle_count_enable_n);

  // apb decode; one wait state so read data comes from a flop
  assign accessPh = psel && penable;
  assign pready = ack_r && clkEn;
  assign xferDone = accessPh && pready;
  assign wrEn = xferDone && pwrite;
  assign hitStatus = paddr == suc_pkg::OFS_STATUS;
  assign hitWraps = paddr == suc_pkg::OFS_WRAPS;
  assign hitCtrl = paddr == suc_pkg::OFS_CTRL;
  assign hitAny = hitStatus || hitWraps || hitCtrl;
  assign pslverr = xferDone && !hitAny;
  assign prdata = prdata_r;

  // read selection, unmapped and reserved bits read as zero
  always_comb begin
    rdMux = suc_pkg::RDATA_RST;
    if (hitStatus) begin
      rdMux[suc_pkg::STAT_CNT_LSB +: 4] = count_r;
      rdMux[suc_pkg::STAT_CARRY_BIT] = !ripple_carry_n;
      rdMux[suc_pkg::STAT_DIR_BIT] = count_direction;
      rdMux[suc_pkg::STAT_LOADN_BIT] = load_n;
    end else if (hitWraps) begin
      rdMux[15:0] = wraps_r;
    end else if (hitCtrl) begin
      rdMux[suc_pkg::CTRL_INHIBIT_BIT] = inhibit_r;
    end
  end

  // a wrap in the clearing cycle is kept, so the set wins
  assign wraps_nxt = (wrEn && hitWraps) ? (wrapEvent ? suc_pkg::WRAPS_ONE : suc_pkg::WRAPS_RST)
                   : (wrapEvent ? 16'(wraps_r + suc_pkg::WRAPS_ONE) : wraps_r);

  // bus state; clkEn low also stalls the bus since pready drops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      prdata_r <= suc_pkg::RDATA_RST;
      inhibit_r <= suc_pkg::CTRL_INHIBIT_RST;
      wraps_r <= suc_pkg::WRAPS_RST;
    end else if (clkEn) begin
      ack_r <= accessPh && !ack_r;
      if (accessPh && !ack_r) begin
        prdata_r <= rdMux;
      end
      if (wrEn && hitCtrl) begin
        inhibit_r <= pwdata[suc_pkg::CTRL_INHIBIT_BIT];
      end
      wraps_r <= wraps_nxt;
    end
  end

  // checks on the counter and its carry
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // helper for the held-state check
  logic holdCase;
  assign holdCase = clkEn && load_n && (parallel_count_enable_n || trickle_count_enable_n);

  AST_LOAD_TAKES_PRESET: assert property (
    clkEn && !load_n |=> count_r == $past(presetVec)
  ) else $error("load did not copy preset bits");

  AST_LOAD_OVER_COUNT: assert property (
    clkEn && !load_n && !parallel_count_enable_n && !trickle_count_enable_n
    |=> {count_bit3, count_bit2, count_bit1, count_bit0} == $past(presetVec)
  ) else $error("counting overrode a load");

  AST_COUNT_UP: assert property (
    clkEn && countGo && count_direction |=> count_r == 4'($past(count_r) + 4'h1)
  ) else $error("up count step wrong");

  AST_COUNT_DOWN: assert property (
    clkEn && countGo && !count_direction |=> count_r == 4'($past(count_r) - 4'h1)
  ) else $error("down count step wrong");

  AST_HOLD_DISABLED: assert property (
    holdCase |=> $stable(count_r)
  ) else $error("count moved with an enable high");

  AST_FROZEN_NO_CLKEN: assert property (
    !clkEn |=> $stable(count_r)
  ) else $error("count moved with clock enable low");

  AST_WRAP_UP: assert property (
    clkEn && countGo && count_direction && count_r == 4'hF |=> count_r == 4'h0
  ) else $error("no wrap from fifteen to zero");

  AST_WRAP_DOWN: assert property (
    clkEn && countGo && !count_direction && count_r == 4'h0 ##1 1'b1 |-> count_r == 4'hF
  ) else $error("no wrap from zero to fifteen");

  AST_CARRY_GATED: assert property (
    trickle_count_enable_n |-> ripple_carry_n
  ) else $error("carry active with trickle enable high");

  AST_CARRY_AT_TOP: assert property (
    count_r == 4'hF && count_direction && !trickle_count_enable_n |-> !ripple_carry_n
  ) else $error("carry missing at fifteen counting up");

  AST_CARRY_AT_BOTTOM: assert property (
    count_r == 4'h0 && !count_direction && !trickle_count_enable_n |-> !ripple_carry_n
  ) else $error("carry missing at zero counting down");

  AST_CARRY_ONLY_TERMINAL: assert property (
    !ripple_carry_n |-> (count_direction ? count_r == 4'hF : count_r == 4'h0)
  ) else $error("carry active away from terminal count");

  AST_CARRY_PULSE_ONE: assert property (
    !ripple_carry_n && clkEn && countGo && $stable(count_direction) ##1 $stable(count_direction)
    |-> ripple_carry_n
  ) else $error("carry longer than one count phase");

  AST_CARRY_FOLLOWS_DIR: assert property (
    count_r == 4'h0 && !trickle_count_enable_n && $changed(count_direction)
    |-> ripple_carry_n == count_direction
  ) else $error("carry did not follow direction at once");

  AST_WRAPS_SET_WINS: assert property (
    clkEn && wrapEvent && wrEn && hitWraps |=> wraps_r == 16'h0001
  ) else $error("wrap lost during clear");

  // every preset bit lands on its own output, whatever the others hold
  AST_PRESET_BIT0: assert property (
    clkEn && !load_n |=> count_bit0 == $past(preset_bit0)
  ) else $error("preset bit 0 not copied");

  AST_PRESET_BIT1: assert property (
    clkEn && !load_n |=> count_bit1 == $past(preset_bit1)
  ) else $error("preset bit 1 not copied");

  AST_PRESET_BIT2: assert property (
    clkEn && !load_n |=> count_bit2 == $past(preset_bit2)
  ) else $error("preset bit 2 not copied");

  AST_PRESET_BIT3: assert property (
    clkEn && !load_n |=> count_bit3 == $past(preset_bit3)
  ) else $error("preset bit 3 not copied");

  // software inhibit blocks counting but never a load
  AST_INHIBIT_HOLDS: assert property (
    clkEn && load_n && inhibit_r |=> $stable(count_r)
  ) else $error("count moved while inhibited");

  // away from its own terminal count the carry stays high
  AST_CARRY_DOWN_AT_TOP: assert property (
    count_r == 4'hF && !count_direction |-> ripple_carry_n
  ) else $error("carry active at fifteen counting down");

  AST_CARRY_UP_AT_BOTTOM: assert property (
    count_r == 4'h0 && count_direction |-> ripple_carry_n
  ) else $error("carry active at zero counting up");

  // bus side: one wait state, one ready cycle, all of it frozen by clkEn
  AST_PREADY_WAIT: assert property (
    psel && !penable |=> !pready
  ) else $error("ready without a wait state");

  AST_PREADY_ONE_CYCLE: assert property (
    pready |=> !pready
  ) else $error("ready held for two cycles");

  AST_FROZEN_NO_READY: assert property (
    !clkEn |-> !pready
  ) else $error("ready with clock enable low");

  AST_BUS_FROZEN: assert property (
    !clkEn |=> $stable(ack_r) && $stable(inhibit_r) && $stable(wraps_r)
  ) else $error("bus state moved with clock enable low");

  AST_CTRL_WRITE: assert property (
    wrEn && hitCtrl |=> inhibit_r == $past(pwdata[suc_pkg::CTRL_INHIBIT_BIT])
  ) else $error("control write not taken");

  AST_CTRL_ONLY_BY_CTRL: assert property (
    wrEn && !hitCtrl |=> $stable(inhibit_r)
  ) else $error("inhibit changed by another address");

  AST_UNMAPPED_READS_ZERO: assert property (
    clkEn && accessPh && !ack_r && !hitAny |=> prdata == 32'h0000_0000
  ) else $error("unmapped read returned data");

  // wrap counter: one up per wrap, a write to the wraps offset clears it
  AST_WRAPS_COUNT: assert property (
    clkEn && wrapEvent && !(wrEn && hitWraps)
    |=> wraps_r == 16'($past(wraps_r) + 16'h0001)
  ) else $error("wrap not counted");

  AST_WRAPS_CLEAR: assert property (
    wrEn && hitWraps && !wrapEvent |=> wraps_r == 16'h0000
  ) else $error("wrap counter not cleared");

endmodule

// File: suc_next_stage.sv
`timescale 1ns/1ns

// next cascaded stage, steps only while the carry pulse is low
module suc_next_stage (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic carryN,
  input wire logic countUp,
  output logic [3:0] upperCnt
);
  // no gating between stages, just as a real chain has none
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      upperCnt <= 4'h0;
    end else if (!carryN) begin
      upperCnt <= countUp ? upperCnt + 4'h1 : upperCnt - 4'h1;
    end
  end
endmodule

// File: suc_pkg.sv
package suc_pkg;

  // counter geometry
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [3:0] CNT_MIN = 4'h0;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // register map, byte addresses on the apb side
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_WRAPS = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;

  // status field positions
  localparam int unsigned STAT_CNT_LSB = 0;
  localparam int unsigned STAT_CARRY_BIT = 4;
  localparam int unsigned STAT_DIR_BIT = 5;
  localparam int unsigned STAT_LOADN_BIT = 6;

  // control field positions and reset values
  localparam int unsigned CTRL_INHIBIT_BIT = 0;
  localparam logic CTRL_INHIBIT_RST = 1'b0;

  // wrap event counter
  localparam int unsigned WRAPS_W = 16;
  localparam logic [15:0] WRAPS_RST = 16'h0000;
  localparam logic [15:0] WRAPS_ONE = 16'h0001;

  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage

// File: tb.sv
`timescale 1ns/1ns

module tb;
  logic mclk = 1'h0, nrst = 1'h0, clkEn = 1'h1, load_n = 1'h1, count_direction = 1'h1;
  logic preset_bit0 = 1'h0, preset_bit1 = 1'h0, preset_bit2 = 1'h0, preset_bit3 = 1'h0;
  logic parallel_count_enable_n = 1'h1, trickle_count_enable_n = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic count_bit0, count_bit1, count_bit2, count_bit3, ripple_carry_n;
  logic [3:0] upperCnt;
  wire logic [3:0] cnt = {count_bit3, count_bit2, count_bit1, count_bit0};
  int miscompares = 0, n_compared = 0;

  // free running bench clock
  always #25 mclk = ~mclk;

  suc_counter u_suc_counter (.mclk, .nrst, .clkEn, .preset_bit0, .preset_bit1, .preset_bit2,
    .preset_bit3, .load_n, .parallel_count_enable_n, .trickle_count_enable_n,
    .count_direction, .count_bit0, .count_bit1, .count_bit2, .count_bit3, .ripple_carry_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  suc_next_stage u_suc_next_stage (.mclk, .nrst, .carryN(ripple_carry_n),
    .countUp(count_direction), .upperCnt);

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // mode m is {load_n, parallel, trickle, direction}; the design sees it one edge on
  task automatic go(input logic [3:0] m, input logic [3:0] p);
    @(posedge mclk);
    {load_n, parallel_count_enable_n} <= m[3:2];
    {trickle_count_enable_n, count_direction} <= m[1:0];
    {preset_bit3, preset_bit2, preset_bit1, preset_bit0} <= p;
  endtask

  // carry is judged against the new mode, count against the old one
  task automatic gc(input logic [3:0] m, p, ec, input logic ek);
    go(m, p);
    #1;
    chk("count", 32'(ec), 32'(cnt));
    chk("carry", 32'(ek), 32'(ripple_carry_n));
  endtask

  // request held until pready is seen at a rising edge, released right after it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, d};
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task automatic t_load;
    #1;
    chk("count", 32'h0, 32'(cnt));
    go(4'h7, 4'hA);
    gc(4'h1, 4'h5, 4'hA, 1'h1);
    gc(4'hF, 4'h0, 4'h5, 1'h1);
    gc(4'hF, 4'h0, 4'h5, 1'h1);
    $display("load test done");
  endtask

  task automatic t_walk;
    logic [3:0] e;
    go(4'h7, 4'hD);
    gc(4'h9, 4'h0, 4'hD, 1'h1);
    for (int i = 1; i < 6; i++) begin
      e = 4'hD + 4'(i);
      gc(4'h9, 4'h0, e, e != 4'hF);
    end
    chk("upper", 32'h1, 32'(upperCnt));
    gc(4'hD, 4'h0, 4'h3, 1'h1);
    gc(4'hA, 4'h0, 4'h3, 1'h1);
    gc(4'h8, 4'h0, 4'h3, 1'h1);
    for (int i = 1; i < 7; i++) begin
      e = 4'h3 - 4'(i);
      gc(4'h8, 4'h0, e, e != 4'h0);
    end
    chk("upper", 32'h0, 32'(upperCnt));
    $display("walk test done");
  endtask

  task automatic t_carry;
    go(4'h7, 4'h0);
    gc(4'hC, 4'h0, 4'h0, 1'h0);
    gc(4'hD, 4'h0, 4'h0, 1'h1);
    go(4'h7, 4'hF);
    gc(4'hD, 4'h0, 4'hF, 1'h0);
    gc(4'hF, 4'h0, 4'hF, 1'h1);
    gc(4'hC, 4'h0, 4'hF, 1'h1);
    gc(4'hD, 4'h0, 4'hF, 1'h0);
    $display("carry test done");
  endtask

  task automatic t_apb;
    apb(1'h0, 12'h008, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'h0, 12'h000, 32'h0);
    chk("status", 32'h7F, rd);
    chk("slverr", 32'h0, 32'(er));
    apb(1'h1, 12'h008, 32'h1);
    gc(4'h9, 4'h0, 4'hF, 1'h0);
    gc(4'h9, 4'h0, 4'hF, 1'h0);
    apb(1'h1, 12'h008, 32'h0);
    go(4'h7, 4'h6);
    gc(4'h9, 4'h0, 4'h6, 1'h1);
    @(posedge mclk);
    clkEn <= 1'h0;
    repeat (3) @(posedge mclk);
    #1;
    chk("count", 32'h7, 32'(cnt));
    @(posedge mclk);
    clkEn <= 1'h1;
    gc(4'hF, 4'h0, 4'h8, 1'h1);
    apb(1'h0, 12'hFFC, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    chk("rdata", 32'h0, rd);
    $display("register test done");
  endtask

  // wrap counter: clear, one wrap, then a wrap that lands on the clearing edge
  task automatic t_wraps;
    apb(1'h1, 12'h004, 32'h0);
    go(4'h7, 4'hE);
    gc(4'h9, 4'h0, 4'hE, 1'h1);
    gc(4'h9, 4'h0, 4'hF, 1'h0);
    gc(4'hF, 4'h0, 4'h0, 1'h1);
    apb(1'h0, 12'h004, 32'h0);
    chk("wraps", 32'h1, rd);
    chk("slverr", 32'h0, 32'(er));
    go(4'h7, 4'h5);
    gc(4'h8, 4'h0, 4'h5, 1'h1);
    gc(4'h8, 4'h0, 4'h4, 1'h1);
    gc(4'h8, 4'h0, 4'h3, 1'h1);
    // count hits zero as the write completes, so the wrap must survive the clear
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk("wraps", 32'h1, rd);
    gc(4'hF, 4'h0, 4'hA, 1'h1);
    $display("wrap test done");
  endtask

  // second reset in mid-run; count and wrap counter go back to zero
  task automatic t_reset;
    @(posedge mclk);
    nrst <= 1'h0;
    #1;
    chk("count", 32'h0, 32'(cnt));
    chk("carry", 32'h1, 32'(ripple_carry_n));
    @(posedge mclk);
    nrst <= 1'h1;
    apb(1'h0, 12'h004, 32'h0);
    chk("wraps", 32'h0, rd);
    gc(4'h9, 4'h0, 4'h0, 1'h1);
    gc(4'hF, 4'h0, 4'h1, 1'h1);
    $display("reset test done");
  endtask

  // reset held five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'h1;
    t_load();
    t_walk();
    t_carry();
    t_apb();
    t_wraps();
    t_reset();
    final_report();
  end
endmodule
